// ---- rsfs_regs.svh ----
/*
 Timing counts of the reset, standby and frame sync controller, in lines or in reference
 clock cycles (50 MHz, 20 ns). Assumes inclusion by bare name from design files.
*/
`ifndef RSFS_REGS_SVH
`define RSFS_REGS_SVH

`define RSFS_CNT_W            16
`define RSFS_HARD_RESET_CYC   16'h0032
`define RSFS_CLK_HOLD_CYC     16'h000A
`define RSFS_FIRST_ACCESS_CYC 16'h0064
`define RSFS_SYNC_PULSE_CYC   16'h0003
`define RSFS_SOFT_RESET_CYC   16'h0014
`define RSFS_LINE_CYC         16'h0010
`define RSFS_PRE_FV_LINES     16'h0008
`define RSFS_EXPOSURE_LINES   16'h0004
`define RSFS_SENSOR_DLY_LINES 16'h0002
`define RSFS_FRAME_LINES      16'h0006
`define RSFS_BLANK_LINES      16'h0002
`define RSFS_PRE_FV_CYC       ((`RSFS_PRE_FV_LINES + `RSFS_EXPOSURE_LINES + `RSFS_SENSOR_DLY_LINES) * `RSFS_LINE_CYC)
`define RSFS_ACTIVE_CYC       (`RSFS_FRAME_LINES * `RSFS_LINE_CYC)
`define RSFS_BLANK_CYC        (`RSFS_BLANK_LINES * `RSFS_LINE_CYC)

`endif

// ---- rsfs_pkg.sv ----
/*
 Types shared by both ends of the reset, standby and frame sync controller.
 Assumes nothing of its surroundings.
*/
package rsfs_pkg;

   typedef enum logic [2:0] {
      DEV_RESET, DEV_BOOT, DEV_IDLE, DEV_WAIT,
      DEV_FRAME, DEV_BLANK, DEV_STANDBY, DEV_SOFT
   } rsfs_dev_state_t;

   typedef enum logic [2:0] {
      HOST_RESET, HOST_RELEASE, HOST_READY, HOST_STANDBY, HOST_SYNC
   } rsfs_host_state_t;

endpackage : rsfs_pkg

// ---- rsfs_if.sv ----
/*
 Link between the controlling party and the camera controller.
 Assumes both ends run on the same reference clock; the trigger, frame valid
 and pixel clock pins each have an active-low output enable beside them.
*/
interface rsfs_if;
   logic reset_n;
   logic standby;
   logic frame_sync;
   logic soft_reset_req;
   logic trig_continuous;
   logic serial_ready;
   logic trigger_out;
   logic trigger_out_oe_n;
   logic frame_valid_out;
   logic frame_valid_out_oe_n;
   logic pixel_clock_out;
   logic pixel_clock_out_oe_n;

   modport dev (
      input  reset_n, standby, frame_sync, soft_reset_req, trig_continuous,
      output serial_ready, trigger_out, trigger_out_oe_n, frame_valid_out,
      output frame_valid_out_oe_n, pixel_clock_out, pixel_clock_out_oe_n
   );

   modport host (
      output reset_n, standby, frame_sync, soft_reset_req, trig_continuous,
      input  serial_ready, trigger_out, trigger_out_oe_n, frame_valid_out,
      input  frame_valid_out_oe_n, pixel_clock_out, pixel_clock_out_oe_n
   );
endinterface : rsfs_if

// ---- rsfs_sync_edge.sv ----
/*
 Two-stage synchroniser with rising edge detect for the sync pulse input.
 Assumes a synchronous active-high reset on the same clock.
*/
module rsfs_sync_edge (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic async_in,
   output logic      level,
   output logic      rise
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // A held level yields a single rise pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise  = sync_reg & ~last_reg;
endmodule : rsfs_sync_edge

// ---- rsfs_device.sv ----
/*
 Camera end of the reset, standby and frame sync controller: hard reset,
 soft reset, hard standby and sync-triggered frame timing. Assumes the
 reference clock drives clock and all link inputs are synchronous to it.
*/
`include "rsfs_regs.svh"

module rsfs_device (
   input  wire logic                clock,
   input  wire logic                rst,
   rsfs_if.dev                      link,
   output rsfs_pkg::rsfs_dev_state_t dev_state,
   output logic                     streaming,
   output logic                     in_standby,
   output logic                     frame_done
);
   import rsfs_pkg::*;

   rsfs_dev_state_t         state_reg;
   rsfs_dev_state_t         state_next;
   logic [`RSFS_CNT_W-1:0]  cnt_reg;
   logic [`RSFS_CNT_W-1:0]  cnt_next;
   logic                    cont_reg;
   logic                    cont_next;
   logic                    fv_reg;
   logic                    trig_reg;
   logic                    pclk_reg;
   logic                    oe_n_reg;
   logic                    ready_reg;
   logic                    stream_reg;
   logic                    stby_reg;
   logic                    done_reg;
   logic                    sync_level;
   logic                    sync_rise;
   logic                    hard_rst;
   logic                    boot_end;
   logic                    pre_end;
   logic                    active_end;
   logic                    blank_end;
   logic                    soft_end;

   rsfs_sync_edge u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in (link.frame_sync),
      .level    (sync_level),
      .rise     (sync_rise)
   );

   function automatic logic at_last(input logic [`RSFS_CNT_W-1:0] cnt,
                                    input logic [`RSFS_CNT_W-1:0] len);
      at_last = (cnt == len - 16'h0001);
   endfunction : at_last

   // Reset pin is sampled like any other synchronous input
   assign hard_rst   = ~link.reset_n;
   assign boot_end   = at_last(cnt_reg, `RSFS_FIRST_ACCESS_CYC);
   // Fixed latency from the sync edge keeps cameras lock-stepped
   assign pre_end    = at_last(cnt_reg, 16'(`RSFS_PRE_FV_CYC));
   assign active_end = at_last(cnt_reg, 16'(`RSFS_ACTIVE_CYC));
   assign blank_end  = at_last(cnt_reg, 16'(`RSFS_BLANK_CYC));
   assign soft_end   = at_last(cnt_reg, `RSFS_SOFT_RESET_CYC);

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 16'h0001;
      cont_next  = cont_reg;
      if (hard_rst) begin
         state_next = DEV_RESET;
         cnt_next   = 16'h0000;
         cont_next  = 1'b0;
      end else begin
         case (state_reg)
            DEV_RESET: begin
               state_next = DEV_BOOT;
               cnt_next   = 16'h0000;
            end
            DEV_BOOT: begin
               if (boot_end) begin
                  state_next = DEV_IDLE;
                  cnt_next   = 16'h0000;
               end
            end
            DEV_IDLE: begin
               cnt_next = 16'h0000;
               if (link.standby) begin
                  state_next = DEV_STANDBY;
               end else if (link.soft_reset_req) begin
                  state_next = DEV_SOFT;
               end else if (sync_rise) begin
                  state_next = DEV_WAIT;
                  cont_next  = link.trig_continuous;
               end
            end
            DEV_WAIT: begin
               if (link.soft_reset_req) begin
                  state_next = DEV_SOFT;
                  cnt_next   = 16'h0000;
               end else if (link.standby) begin
                  state_next = DEV_STANDBY;
                  cnt_next   = 16'h0000;
               end else if (pre_end) begin
                  state_next = DEV_FRAME;
                  cnt_next   = 16'h0000;
               end
            end
            DEV_FRAME: begin
               // Standby lets the current frame finish, well inside two frames
               if (link.soft_reset_req) begin
                  state_next = DEV_SOFT;
                  cnt_next   = 16'h0000;
               end else if (active_end) begin
                  state_next = DEV_BLANK;
                  cnt_next   = 16'h0000;
               end
            end
            DEV_BLANK: begin
               if (link.soft_reset_req) begin
                  state_next = DEV_SOFT;
                  cnt_next   = 16'h0000;
               end else if (blank_end) begin
                  cnt_next = 16'h0000;
                  if (link.standby) begin
                     state_next = DEV_STANDBY;
                  end else if (cont_reg) begin
                     state_next = DEV_FRAME;
                  end else begin
                     state_next = DEV_IDLE;
                  end
               end
            end
            DEV_STANDBY: begin
               cnt_next = 16'h0000;
               if (!link.standby) begin
                  state_next = DEV_IDLE;
                  cont_next  = 1'b0;
               end
            end
            DEV_SOFT: begin
               cont_next = 1'b0;
               if (soft_end) begin
                  state_next = DEV_IDLE;
                  cnt_next   = 16'h0000;
               end
            end
            default: begin
               state_next = DEV_RESET;
               cnt_next   = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= DEV_RESET;
         cnt_reg   <= 16'h0000;
         cont_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         cont_reg  <= cont_next;
      end
   end

   // Pins stay released from the reset state until boot starts
   always_ff @(posedge clock) begin
      if (rst) begin
         oe_n_reg  <= 1'b1;
         fv_reg    <= 1'b0;
         trig_reg  <= 1'b0;
         pclk_reg  <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         oe_n_reg  <= (state_next == DEV_RESET);
         fv_reg    <= (state_next == DEV_FRAME);
         trig_reg  <= sync_level & (state_next != DEV_RESET);
         pclk_reg  <= (state_next == DEV_RESET) ? 1'b0 : ~pclk_reg;
         ready_reg <= (state_next != DEV_RESET) && (state_next != DEV_BOOT);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         stream_reg <= 1'b0;
         stby_reg   <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         stream_reg <= (state_next == DEV_WAIT) || (state_next == DEV_FRAME)
                       || (state_next == DEV_BLANK);
         stby_reg   <= (state_next == DEV_STANDBY);
         done_reg   <= (state_reg == DEV_FRAME) && (state_next != DEV_FRAME);
      end
   end

   assign link.serial_ready         = ready_reg;
   assign link.trigger_out          = trig_reg;
   assign link.trigger_out_oe_n     = oe_n_reg;
   assign link.frame_valid_out      = fv_reg;
   assign link.frame_valid_out_oe_n = oe_n_reg;
   assign link.pixel_clock_out      = pclk_reg;
   assign link.pixel_clock_out_oe_n = oe_n_reg;
   assign dev_state                 = state_reg;
   assign streaming                 = stream_reg;
   assign in_standby                = stby_reg;
   assign frame_done                = done_reg;
endmodule : rsfs_device

// ---- rsfs_host.sv ----
/*
 Controlling end: sequences hard reset, soft reset, standby and sync pulses
 toward the camera. Assumes the reference clock it shares keeps running.
*/
`include "rsfs_regs.svh"

module rsfs_host (
   input  wire logic                 clock,
   input  wire logic                 rst,
   rsfs_if.host                      link,
   input  wire logic                 hard_reset_req,
   input  wire logic                 soft_reset_cmd,
   input  wire logic                 standby_req,
   input  wire logic                 sync_req,
   input  wire logic                 continuous_mode,
   output rsfs_pkg::rsfs_host_state_t host_state,
   output logic                      host_ready,
   output logic                      frame_active
);
   import rsfs_pkg::*;

   rsfs_host_state_t        state_reg;
   rsfs_host_state_t        state_next;
   logic [`RSFS_CNT_W-1:0]  cnt_reg;
   logic [`RSFS_CNT_W-1:0]  cnt_next;
   logic                    rstn_reg;
   logic                    stby_reg;
   logic                    sync_reg;
   logic                    soft_reg;
   logic                    cont_reg;
   logic                    ready_reg;
   logic                    fv_reg;
   logic                    rst_done;
   logic                    wait_done;
   logic                    hold_done;
   logic                    pulse_done;

   // Clock is shared, so it already runs around every edge of reset
   assign rst_done   = (cnt_reg >= `RSFS_HARD_RESET_CYC - 16'h0001);
   assign wait_done  = (cnt_reg >= `RSFS_FIRST_ACCESS_CYC - 16'h0001);
   assign hold_done  = (cnt_reg >= `RSFS_CLK_HOLD_CYC - 16'h0001);
   assign pulse_done = (cnt_reg == `RSFS_SYNC_PULSE_CYC - 16'h0001);

   always_comb begin
      state_next = state_reg;
      cnt_next   = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;
      if (hard_reset_req) begin
         state_next = HOST_RESET;
         cnt_next   = 16'h0000;
      end else begin
         case (state_reg)
            HOST_RESET: begin
               if (rst_done) begin
                  state_next = HOST_RELEASE;
                  cnt_next   = 16'h0000;
               end
            end
            HOST_RELEASE: begin
               if (wait_done && link.serial_ready) begin
                  state_next = HOST_READY;
               end
            end
            HOST_READY: begin
               cnt_next = 16'h0000;
               if (standby_req) begin
                  state_next = HOST_STANDBY;
               end else if (sync_req) begin
                  state_next = HOST_SYNC;
               end
            end
            HOST_STANDBY: begin
               if (!standby_req && hold_done) begin
                  state_next = HOST_READY;
               end
            end
            HOST_SYNC: begin
               if (pulse_done) begin
                  state_next = HOST_READY;
               end
            end
            default: begin
               state_next = HOST_RESET;
               cnt_next   = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= HOST_RESET;
         cnt_reg   <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rstn_reg  <= 1'b0;
         stby_reg  <= 1'b0;
         sync_reg  <= 1'b0;
         soft_reg  <= 1'b0;
         cont_reg  <= 1'b0;
         ready_reg <= 1'b0;
         fv_reg    <= 1'b0;
      end else begin
         rstn_reg  <= (state_next != HOST_RESET);
         stby_reg  <= (state_next == HOST_STANDBY);
         sync_reg  <= (state_next == HOST_SYNC);
         soft_reg  <= soft_reset_cmd && (state_reg == HOST_READY) && !standby_req
                      && !sync_req && !hard_reset_req;
         cont_reg  <= continuous_mode;
         ready_reg <= (state_next == HOST_READY);
         fv_reg    <= link.frame_valid_out & ~link.frame_valid_out_oe_n;
      end
   end

   assign link.reset_n         = rstn_reg;
   assign link.standby         = stby_reg;
   assign link.frame_sync      = sync_reg;
   assign link.soft_reset_req  = soft_reg;
   assign link.trig_continuous = cont_reg;
   assign host_state           = state_reg;
   assign host_ready           = ready_reg;
   assign frame_active         = fv_reg;
endmodule : rsfs_host

// ---- rsfs_asserts.sv ----
/*
 Checker on the link between the controlling end and the camera end.
 Assumes the testbench instantiates it beside the link, on the same clock.
*/
`include "rsfs_regs.svh"

module rsfs_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic reset_n,
   input wire logic standby,
   input wire logic frame_sync,
   input wire logic soft_reset_req,
   input wire logic trig_continuous,
   input wire logic serial_ready,
   input wire logic trigger_out,
   input wire logic trigger_out_oe_n,
   input wire logic frame_valid_out,
   input wire logic frame_valid_out_oe_n,
   input wire logic pixel_clock_out,
   input wire logic pixel_clock_out_oe_n
);
   import rsfs_pkg::*;
   localparam int PRE_FV = `RSFS_PRE_FV_CYC;
   localparam int ACT    = `RSFS_ACTIVE_CYC;

   logic [15:0] low_cnt_reg;
   logic [15:0] hi_cnt_reg;
   logic [15:0] since_sync_reg;
   logic [15:0] fv_cnt_reg;
   logic        fs_q_reg;

   // Saturating so long idle stretches never wrap into a false short count
   function automatic logic [15:0] sat(input logic [15:0] v);
      return (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : sat

   always_ff @(posedge clock) begin
      low_cnt_reg    <= rst ? 16'h0001 : (reset_n ? 16'h0000 : sat(low_cnt_reg));
      hi_cnt_reg     <= (rst || !reset_n) ? 16'h0000 : sat(hi_cnt_reg);
      since_sync_reg <= (rst || (frame_sync && !fs_q_reg)) ? 16'h0000 : sat(since_sync_reg);
      fv_cnt_reg     <= (rst || !frame_valid_out) ? 16'h0000 : sat(fv_cnt_reg);
      fs_q_reg       <= rst ? 1'b0 : frame_sync;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_reset_hiz: assert property (!reset_n ##1 !reset_n |=>
      trigger_out_oe_n && frame_valid_out_oe_n && pixel_clock_out_oe_n)
      else $error("output driven during hard reset");
   chk_reset_quiet: assert property (!reset_n ##1 !reset_n |=>
      !frame_valid_out && !serial_ready)
      else $error("frame valid or ready during hard reset");
   chk_reset_width: assert property ($rose(reset_n) |->
      low_cnt_reg >= `RSFS_HARD_RESET_CYC)
      else $error("hard reset pulse too short");
   chk_first_access: assert property (serial_ready |->
      hi_cnt_reg >= `RSFS_FIRST_ACCESS_CYC)
      else $error("serial ready too soon after reset release");
   chk_sync_width: assert property ($rose(frame_sync) |-> frame_sync [*3])
      else $error("sync pulse shorter than three cycles");
   chk_trig_follow: assert property ($rose(frame_sync) && serial_ready |->
      ##[2:4] trigger_out)
      else $error("sync pulse not forwarded to trigger");
   chk_fv_delay: assert property ($rose(frame_valid_out) |->
      since_sync_reg >= PRE_FV)
      else $error("frame valid too soon after sync");
   chk_fv_single: assert property ($rose(frame_valid_out) && !trig_continuous |->
      since_sync_reg <= PRE_FV + 16)
      else $error("single shot frame without its own sync");
   chk_fv_width: assert property ($fell(frame_valid_out) && reset_n &&
      !$past(soft_reset_req) && !$past(soft_reset_req, 2) && !$past(soft_reset_req, 3)
      |-> fv_cnt_reg == ACT)
      else $error("frame valid length wrong");
   chk_soft_stop: assert property (soft_reset_req && frame_valid_out |->
      ##[1:3] !frame_valid_out)
      else $error("soft reset did not stop the frame");
   chk_standby_nofv: assert property (standby && $past(standby) && $past(standby, 2)
      |-> !$rose(frame_valid_out))
      else $error("frame started during standby");
   // Pixel clock is the time base for frame alignment, so it must run whenever driven
   chk_pclk_toggle: assert property (!pixel_clock_out_oe_n |->
      pixel_clock_out != $past(pixel_clock_out))
      else $error("pixel clock did not toggle while driven");
endmodule : rsfs_asserts

// ---- reset_standby_frame_sync_ctrl_test.sv ----
/*
 Self-checking bench: host and camera joined by one link, and a second camera
 that mirrors the first, then is driven directly for misuse cases.
 Assumes the design files and rsfs_regs.svh are compiled first.
*/
`include "rsfs_regs.svh"

module reset_standby_frame_sync_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   import rsfs_pkg::*;
   localparam int PRE_FV = `RSFS_PRE_FV_CYC;
   localparam int FRAME  = `RSFS_ACTIVE_CYC + `RSFS_BLANK_CYC;
   localparam int BOOT   = `RSFS_HARD_RESET_CYC + `RSFS_FIRST_ACCESS_CYC;

   logic clock, rst, hard_reset_req, soft_reset_cmd, standby_req, sync_req, continuous_mode;
   logic own, b_reset_n, b_frame_sync, b_soft, fv_q, fv_b_q;
   logic host_ready, frame_active, streaming, in_standby, frame_done;
   logic streaming_b, in_standby_b, frame_done_b;
   rsfs_host_state_t host_state;
   rsfs_dev_state_t  dev_state, dev_state_b;
   int n_errors = 0, checked = 0, seed, n_fv = 0, n_fv_b = 0, n_done = 0, n_trig = 0;
   int n_diff = 0, n, t;

   rsfs_if link();
   rsfs_if link_b();

   rsfs_host i_rsfs_host (.clock(clock), .rst(rst), .link(link),
      .hard_reset_req(hard_reset_req), .soft_reset_cmd(soft_reset_cmd),
      .standby_req(standby_req), .sync_req(sync_req), .continuous_mode(continuous_mode),
      .host_state(host_state), .host_ready(host_ready), .frame_active(frame_active));
   rsfs_device i_rsfs_device (.clock(clock), .rst(rst), .link(link), .dev_state(dev_state),
      .streaming(streaming), .in_standby(in_standby), .frame_done(frame_done));
   rsfs_device i_rsfs_device_b (.clock(clock), .rst(rst), .link(link_b),
      .dev_state(dev_state_b), .streaming(streaming_b), .in_standby(in_standby_b),
      .frame_done(frame_done_b));
   rsfs_asserts i_rsfs_asserts (.clock(clock), .rst(rst), .reset_n(link.reset_n),
      .standby(link.standby), .frame_sync(link.frame_sync),
      .soft_reset_req(link.soft_reset_req), .trig_continuous(link.trig_continuous),
      .serial_ready(link.serial_ready), .trigger_out(link.trigger_out),
      .trigger_out_oe_n(link.trigger_out_oe_n), .frame_valid_out(link.frame_valid_out),
      .frame_valid_out_oe_n(link.frame_valid_out_oe_n),
      .pixel_clock_out(link.pixel_clock_out),
      .pixel_clock_out_oe_n(link.pixel_clock_out_oe_n));

   // Second camera sees the same host until the misuse phase takes it over
   always_comb begin
      link_b.reset_n         = own ? b_reset_n : link.reset_n;
      link_b.standby         = own ? 1'b0 : link.standby;
      link_b.frame_sync      = own ? b_frame_sync : link.frame_sync;
      link_b.soft_reset_req  = own ? b_soft : link.soft_reset_req;
      link_b.trig_continuous = own ? 1'b0 : link.trig_continuous;
   end

   always @(posedge clock) begin
      fv_q   <= link.frame_valid_out;
      fv_b_q <= link_b.frame_valid_out;
      if (link.frame_valid_out === 1'b1 && fv_q === 1'b0) n_fv++;
      if (link_b.frame_valid_out === 1'b1 && fv_b_q === 1'b0) n_fv_b++;
      if (frame_done === 1'b1) n_done++;
      if (link.trigger_out === 1'b1) n_trig++;
      if (!own && {link.frame_valid_out, streaming, in_standby, frame_done}
          !== {link_b.frame_valid_out, streaming_b, in_standby_b, frame_done_b}) n_diff++;
   end

   // Reference clock never stops, so hold times around reset and standby are met
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   task automatic wait_on(input int sel, input logic lvl, input int lim, output int cyc);
      logic s;
      cyc = 0;
      do begin
         @(negedge clock);
         cyc++;
         case (sel)
            0: s = host_ready;
            1: s = link.frame_valid_out;
            2: s = in_standby;
            3: s = link_b.serial_ready;
            default: s = (dev_state == DEV_IDLE);
         endcase
         if (cyc > lim) begin
            n_errors++;
            $display("[FAIL] wait %0d expected %0h seen %0h", sel, lvl, s);
            final_report();
         end
      end while (s !== lvl);
   endtask : wait_on

   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(negedge clock);
      sig = 1'b0;
   endtask : pulse

   initial begin
      seed = 60842;
      {rst, hard_reset_req, soft_reset_cmd, standby_req, sync_req, continuous_mode} = 6'h20;
      {own, b_reset_n, b_frame_sync, b_soft} = 4'h0;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      wait_on(0, 1'b1, 400, t);
      check("boot_time", t >= BOOT, 16'h0001);
      check("boot_state", dev_state, DEV_IDLE);
      check("host_state", host_state, HOST_READY);
      $display("boot done");
      for (int i = 0; i < 2; i++) begin
         {n_fv, n_done, n_trig} = '0;
         repeat (($random(seed) & 15) + 1) @(negedge clock);
         pulse(sync_req);
         wait_on(1, 1'b1, PRE_FV + 40, t);
         check("sync_to_fv", t >= PRE_FV, 16'h0001);
         // Host view of frame valid trails the pin by one register
         check("fa_late", frame_active, 16'h0000);
         @(negedge clock);
         check("frame_active", frame_active, 16'h0001);
         check("streaming", streaming, 16'h0001);
         wait_on(4, 1'b1, FRAME + 40, t);
         check("stream_end", streaming, 16'h0000);
         repeat (2 * FRAME) @(negedge clock);
         check("single_frames", n_fv, 16'h0001);
         check("frame_done", n_done, 16'h0001);
         check("trigger_cycles", n_trig, 16'h0003);
      end
      $display("single shot done");
      continuous_mode = 1'b1;
      n_fv = 0;
      pulse(sync_req);
      repeat (PRE_FV + 3 * FRAME + 20) @(negedge clock);
      check("cont_frames", n_fv >= 3, 16'h0001);
      standby_req = 1'b1;
      wait_on(2, 1'b1, 2 * FRAME, t);
      check("standby_fv", link.frame_valid_out, 16'h0000);
      n = n_fv;
      repeat (FRAME) @(negedge clock);
      check("standby_quiet", n_fv, n);
      standby_req = 1'b0;
      continuous_mode = 1'b0;
      wait_on(2, 1'b0, 20, t);
      check("standby_exit", dev_state, DEV_IDLE);
      for (int i = 0; i < 3; i++) begin
         // Middle round enters standby while the sync delay is running
         if (i == 1) begin
            pulse(sync_req);
         end
         standby_req = 1'b1;
         wait_on(2, 1'b1, 8, t);
         repeat (10 + ($random(seed) & 31)) @(negedge clock);
         standby_req = 1'b0;
         wait_on(2, 1'b0, 8, t);
      end
      $display("continuous and standby done");
      pulse(sync_req);
      wait_on(1, 1'b1, PRE_FV + 40, t);
      // Soft reset lands in the frame, its blanking or idle
      repeat ($random(seed) & 127) @(negedge clock);
      pulse(soft_reset_cmd);
      wait_on(1, 1'b0, 8, t);
      check("soft_state", dev_state, DEV_SOFT);
      check("soft_stream", streaming, 16'h0000);
      wait_on(4, 1'b1, `RSFS_SOFT_RESET_CYC + 8, t);
      $display("soft reset done");
      pulse(sync_req);
      wait_on(1, 1'b1, PRE_FV + 40, t);
      pulse(hard_reset_req);
      repeat (5) @(negedge clock);
      check("hiz_outputs", {link.trigger_out_oe_n, link.frame_valid_out_oe_n,
         link.pixel_clock_out_oe_n, link.frame_valid_out}, 16'h000E);
      check("reset_state", dev_state, DEV_RESET);
      wait_on(0, 1'b1, 400, t);
      check("reboot_time", t >= `RSFS_FIRST_ACCESS_CYC, 16'h0001);
      check("fv_align", n_diff, 16'h0000);
      $display("hard reset done");
      own = 1'b1;
      repeat (60) @(negedge clock);
      b_reset_n = 1'b1;
      repeat (20) @(negedge clock);
      pulse(b_soft);
      repeat (2) @(negedge clock);
      check("early_soft", dev_state_b, DEV_BOOT);
      wait_on(3, 1'b1, 120, t);
      check("early_ready", t >= 77, 16'h0001);
      n_fv_b = 0;
      b_frame_sync = 1'b1;
      repeat (PRE_FV + 2 * FRAME) @(negedge clock);
      check("held_sync", n_fv_b, 16'h0001);
      b_frame_sync = 1'b0;
      $display("misuse done");
      final_report();
   end
endmodule : reset_standby_frame_sync_ctrl_test
